//--- imsq_top.sv
// Ink maintenance sequencer with AHB-Lite register slave
// What this block does
// R1: Wipe moves carriage left to right across the rubber blade half.
// R2: Rub moves carriage right to left across the felt blade half.
// R3: Ink absorb pumps programmed steps, heads capped, air valve closed.
// R4: False absorb pumps programmed steps, capped, valve open, empties caps.
// R5: Micro absorb pumps programmed steps, capped, valve open, expels bubbles.
// R6: Every flush first moves carriage to false-absorb position, then fires.
// R7: Power flush fires 4000 shots at optimum plus boost, capped at maximum.
// R8: Normal flush fires black at 48 per second, color at 36 per second.
// R9: Cleaning flush fires 200 black and 2000 color normal-dot shots.
// R10: Micro vibration pulses only while carriage motor accelerates.
// R11: Periodic flush timer clears on print start or normal flush.
// R12: Auto-clean timer always runs, clears when ink absorb executes.
// R13: Print timer counts cap open to waiting, clears on ink absorb.
// R14: Idle timer counts capped, held after absorb until power-on flush.
// R15: Power-off timer starts at power-off, stops at next ink absorb.
// R16: Cap-ink counters accumulate shots; over limit force false absorb, clear.
// R17: Order counter picks normal, strong, strong-rub cleaning; software overrides.
// R18: Waste counter flags maintenance error over limit; storage reset clears.
// R19: Use counters add cleaning, flushing ink and power-fail amount.
// R20: Use counter clears when its cartridge is removed during exchange.
// R21: Timers and counters are readable and restorable for storage.
// R22: Order counter advances 1 to 2, 2 to 3, 3 back to 1.
// R23: All timers and counters except the order counter saturate instead of wrapping.
// R24: Step counts and limits are loadable configuration registers.
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module imsq_top #(
  parameter int unsigned TICK_CYC = imsq_pkg::TICK_CYC,
  parameter int unsigned BLK_PER = imsq_pkg::BLK_PER_CYC,
  parameter int unsigned COL_PER = imsq_pkg::COL_PER_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cap_closed_pin,
  input wire logic cr_accel_pin,
  input wire logic power_fail_pin,
  input wire logic carriage_done,
  output logic carriage_go,
  output logic carriage_dir_right,
  output logic [1:0] carriage_target,
  output logic pump_step,
  output logic pump_on,
  output logic valve_open,
  output logic fire_black,
  output logic fire_color,
  output logic drive_power,
  output logic [9:0] drive_volt,
  output logic micro_vib,
  output logic busy,
  output logic maint_error
);
  typedef struct packed {
    imsq_pkg::imsq_st_e st;
    logic [3:0] op;
    logic wr_pend;
    logic rd_pend;
    logic [5:0] idx;
    logic [31:0] rdata;
    logic [imsq_pkg::CFG_N-1:0][31:0] cfg;
    logic [imsq_pkg::NV_N-1:0][31:0] nv;
    logic [31:0] tick;
    logic [31:0] gap;
    logic [31:0] btmr;
    logic [31:0] ctmr;
    logic [31:0] left;
    logic [31:0] bleft;
    logic [31:0] cleft;
    logic [31:0] vcnt;
    logic print_run;
    logic idle_hold;
    logic off_run;
    logic cap_q;
    logic pf_q;
    logic refused;
    logic go;
    logic dir;
    logic [1:0] tgt;
    logic pstep;
    logic pon;
    logic valve;
    logic fire_b;
    logic fire_c;
    logic dpow;
    logic [9:0] volt;
    logic vib;
    logic merr;
  } imsq_top_s;
  imsq_top_s r, n;
  logic [2:0] pins_s;
  logic cap_s, accel_s, pf_s;

  // Saturating add for every timer and counter except the order counter
  function automatic logic [31:0] sat_add(input logic [31:0] a,
                                          input logic [31:0] b);
    logic [32:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[32] ? 32'hffff_ffff : s[31:0]; // [R23]
  endfunction

  // ==========================================================
  // Pin synchronisers
  imsq_sync #(.W(3)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin({power_fail_pin, cr_accel_pin, cap_closed_pin}),
    .level(pins_s)
  );
  assign cap_s = pins_s[0];
  assign accel_s = pins_s[1];
  assign pf_s = pins_s[2];

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [31:0] ev;
    logic [3:0] sop;
    logic [10:0] boost;
    logic [5:0] ci;
    logic [5:0] ni;
    logic wr_now;
    ev = '0;
    sop = imsq_pkg::OP_NONE;
    boost = '0;
    ci = '0;
    ni = '0;
    wr_now = 1'b0;
    n = r;
    n.go = 1'b0;
    n.pstep = 1'b0;
    n.fire_b = 1'b0;
    n.fire_c = 1'b0;
    n.vib = 1'b0;
    n.cap_q = cap_s;
    n.pf_q = pf_s;
    wr_now = r.wr_pend;
    ci = 6'(r.idx - 6'(imsq_pkg::ADDR_CFG >> 2));
    ni = 6'(r.idx - 6'(imsq_pkg::ADDR_NV >> 2));
    if (wr_now && r.idx == 6'(imsq_pkg::ADDR_EVT >> 2)) ev = hwdata;
    // Status write-one-clears the refused flag before any new set
    if (wr_now && r.idx == 6'(imsq_pkg::ADDR_STAT >> 2) && hwdata[8])
      n.refused = 1'b0;

    // Time base tick and timers
    if (r.tick == '0) begin
      n.tick = TICK_CYC - 1;
      n.nv[imsq_pkg::NV_PFL] = sat_add(r.nv[imsq_pkg::NV_PFL], 32'h1);
      n.nv[imsq_pkg::NV_CLT] = sat_add(r.nv[imsq_pkg::NV_CLT], 32'h1); // [R12]
      if (r.print_run)
        n.nv[imsq_pkg::NV_PRT] = sat_add(r.nv[imsq_pkg::NV_PRT], 32'h1); // [R13]
      if (cap_s && !r.idle_hold && r.st == imsq_pkg::ST_IDLE)
        n.nv[imsq_pkg::NV_IDL] = sat_add(r.nv[imsq_pkg::NV_IDL], 32'h1); // [R14]
      if (r.off_run)
        n.nv[imsq_pkg::NV_OFF] = sat_add(r.nv[imsq_pkg::NV_OFF], 32'h1); // [R15]
    end else begin
      n.tick = r.tick - 32'h1;
    end

    if (ev[1]) n.print_run = 1'b0; // [R13]
    // Cap release starts print time and clears idle time
    if (r.cap_q && !cap_s) begin
      n.print_run = 1'b1; // [R13]
      n.nv[imsq_pkg::NV_IDL] = '0; // [R14]
    end

    // Software events
    if (ev[0]) n.nv[imsq_pkg::NV_PFL] = '0; // [R11]
    if (ev[2]) begin
      n.off_run = 1'b1; // [R15]
      n.nv[imsq_pkg::NV_OFF] = '0;
    end
    if (ev[3]) n.idle_hold = 1'b0; // [R14]
    if (r.cfg[imsq_pkg::CFG_CTRL][1]) begin
      if (ev[4]) n.nv[imsq_pkg::NV_USEK] = '0; // [R20]
      if (ev[5]) begin
        n.nv[imsq_pkg::NV_USEY] = '0; // [R20]
        n.nv[imsq_pkg::NV_USEM] = '0;
        n.nv[imsq_pkg::NV_USEC] = '0;
      end
    end

    // Fixed ink charge when power fails during pumping
    if (pf_s && !r.pf_q && r.st == imsq_pkg::ST_PUMP) begin
      for (int k = imsq_pkg::NV_USEK; k <= imsq_pkg::NV_USEC; k++)
        n.nv[k] = sat_add(r.nv[k], imsq_pkg::PWRFAIL_INK); // [R19]
    end

    // Operation sequencer
    unique case (r.st)
      imsq_pkg::ST_IDLE: begin
        if (wr_now && r.idx == 6'(imsq_pkg::ADDR_CMD >> 2)) begin
          sop = hwdata[3:0];
        end else if (cap_s && (r.nv[imsq_pkg::NV_CAPB] >
                     r.cfg[imsq_pkg::CFG_CAPLIM] ||
                     r.nv[imsq_pkg::NV_CAPC] >
                     r.cfg[imsq_pkg::CFG_CAPLIM])) begin
          sop = imsq_pkg::OP_FALSE; // [R16]
          if (r.nv[imsq_pkg::NV_CAPB] > r.cfg[imsq_pkg::CFG_CAPLIM])
            n.nv[imsq_pkg::NV_CAPB] = '0; // [R16]
          if (r.nv[imsq_pkg::NV_CAPC] > r.cfg[imsq_pkg::CFG_CAPLIM])
            n.nv[imsq_pkg::NV_CAPC] = '0; // [R16]
        end
        if (sop != imsq_pkg::OP_NONE) n.op = sop;
        n.btmr = '0;
        n.ctmr = '0;
        n.gap = '0;
        if (sop == imsq_pkg::OP_WIPE || sop == imsq_pkg::OP_RUB) begin
          n.go = 1'b1;
          n.dir = (sop == imsq_pkg::OP_WIPE); // [R1] [R2]
          n.tgt = (sop == imsq_pkg::OP_WIPE) ? imsq_pkg::TGT_WIPE
                                             : imsq_pkg::TGT_RUB;
          n.st = imsq_pkg::ST_MOVE;
        end else if (sop == imsq_pkg::OP_ABSORB ||
                     sop == imsq_pkg::OP_FALSE ||
                     sop == imsq_pkg::OP_MICRO) begin
          if (cap_s) begin
            n.left = (sop == imsq_pkg::OP_ABSORB) ?
                     r.cfg[imsq_pkg::CFG_ABS] :
                     (sop == imsq_pkg::OP_FALSE) ?
                     r.cfg[imsq_pkg::CFG_FALSE] :
                     r.cfg[imsq_pkg::CFG_MICRO]; // [R24]
            n.valve = (sop != imsq_pkg::OP_ABSORB); // [R3] [R4] [R5]
            n.pon = 1'b1;
            n.st = imsq_pkg::ST_PUMP;
          end else begin
            n.refused = 1'b1; // [R3]
          end
        end else if (sop == imsq_pkg::OP_FLPOW ||
                     sop == imsq_pkg::OP_FLNORM ||
                     sop == imsq_pkg::OP_FLCLN) begin
          n.go = 1'b1;
          n.tgt = imsq_pkg::TGT_FLUSH; // [R6]
          n.dir = 1'b0;
          n.st = imsq_pkg::ST_MOVE;
          boost = {1'b0, r.cfg[imsq_pkg::CFG_VOLT][9:0]} +
                  {1'b0, imsq_pkg::VOLT_BOOST};
          n.dpow = (sop == imsq_pkg::OP_FLPOW);
          if (sop == imsq_pkg::OP_FLPOW) begin
            n.volt = (boost > {1'b0, imsq_pkg::VOLT_MAX}) ?
                     imsq_pkg::VOLT_MAX : boost[9:0]; // [R7]
            n.bleft = imsq_pkg::SHOTS_POWER;
            n.cleft = imsq_pkg::SHOTS_POWER;
          end else begin
            n.volt = r.cfg[imsq_pkg::CFG_VOLT][9:0]; // [R8] [R9]
            n.bleft = (sop == imsq_pkg::OP_FLNORM) ?
                      imsq_pkg::SHOTS_NF_BLK : imsq_pkg::SHOTS_CF_BLK;
            n.cleft = (sop == imsq_pkg::OP_FLNORM) ?
                      imsq_pkg::SHOTS_NF_COL : imsq_pkg::SHOTS_CF_COL;
          end
        end else if (sop == imsq_pkg::OP_CLNDONE) begin
          n.nv[imsq_pkg::NV_ORD] =
            (r.nv[imsq_pkg::NV_ORD] == 32'h0000_0001) ? 32'h0000_0002 :
            (r.nv[imsq_pkg::NV_ORD] == 32'h0000_0002) ? 32'h0000_0003 :
            32'h0000_0001; // [R22] [R17]
        end else if (sop == imsq_pkg::OP_NVRST) begin
          n.nv[imsq_pkg::NV_WASTE] = '0; // [R18]
        end
      end
      imsq_pkg::ST_MOVE: begin
        if (carriage_done) begin
          if (r.tgt == imsq_pkg::TGT_FLUSH) n.st = imsq_pkg::ST_FIRE; // [R6]
          else n.st = imsq_pkg::ST_IDLE;
        end
      end
      imsq_pkg::ST_PUMP: begin
        if (r.gap != '0) begin
          n.gap = r.gap - 32'h1;
        end else if (r.left == '0) begin
          n.pon = 1'b0;
          n.valve = 1'b0;
          n.st = imsq_pkg::ST_IDLE;
          if (r.op == imsq_pkg::OP_ABSORB) begin
            n.nv[imsq_pkg::NV_CLT] = '0; // [R12]
            n.nv[imsq_pkg::NV_PRT] = '0; // [R13]
            n.off_run = 1'b0; // [R15]
            n.idle_hold = 1'b1; // [R14]
          end
        end else begin
          n.pstep = 1'b1; // [R3] [R4] [R5]
          n.left = r.left - 32'h1;
          n.gap = imsq_pkg::PUMP_GAP_CYC - 1;
          n.nv[imsq_pkg::NV_WASTE] =
            sat_add(r.nv[imsq_pkg::NV_WASTE], 32'h1); // [R18]
          for (int k = imsq_pkg::NV_USEK; k <= imsq_pkg::NV_USEC; k++)
            n.nv[k] = sat_add(n.nv[k], 32'h1); // [R19]
        end
      end
      imsq_pkg::ST_FIRE: begin
        if (r.bleft != '0) begin
          if (r.btmr == '0) begin
            n.fire_b = 1'b1; // [R7] [R8] [R9]
            n.bleft = r.bleft - 32'h1;
            n.btmr = (r.op == imsq_pkg::OP_FLNORM) ? BLK_PER - 1
                     : imsq_pkg::SHOT_GAP_CYC - 1; // [R8]
            n.nv[imsq_pkg::NV_CAPB] =
              sat_add(r.nv[imsq_pkg::NV_CAPB], 32'h1); // [R16]
            n.nv[imsq_pkg::NV_USEK] =
              sat_add(n.nv[imsq_pkg::NV_USEK], 32'h1); // [R19]
          end else begin
            n.btmr = r.btmr - 32'h1;
          end
        end
        if (r.cleft != '0) begin
          if (r.ctmr == '0) begin
            n.fire_c = 1'b1; // [R7] [R8] [R9]
            n.cleft = r.cleft - 32'h1;
            n.ctmr = (r.op == imsq_pkg::OP_FLNORM) ? COL_PER - 1
                     : imsq_pkg::SHOT_GAP_CYC - 1; // [R8]
            n.nv[imsq_pkg::NV_CAPC] =
              sat_add(r.nv[imsq_pkg::NV_CAPC], 32'h1); // [R16]
            for (int k = imsq_pkg::NV_USEY; k <= imsq_pkg::NV_USEC; k++)
              n.nv[k] = sat_add(n.nv[k], 32'h1); // [R19]
          end else begin
            n.ctmr = r.ctmr - 32'h1;
          end
        end
        if (r.bleft == '0 && r.cleft == '0) begin
          n.st = imsq_pkg::ST_IDLE;
          n.dpow = 1'b0;
          if (r.op == imsq_pkg::OP_FLNORM)
            n.nv[imsq_pkg::NV_PFL] = '0; // [R11]
        end
      end
      default: n.st = imsq_pkg::ST_IDLE;
    endcase

    // Micro vibration only during carriage acceleration
    if (r.cfg[imsq_pkg::CFG_CTRL][0] && accel_s &&
        r.st == imsq_pkg::ST_IDLE) begin
      if (r.vcnt == '0) begin
        n.vib = 1'b1; // [R10]
        n.vcnt = imsq_pkg::VIB_GAP_CYC - 1;
      end else begin
        n.vcnt = r.vcnt - 32'h1;
      end
    end else begin
      n.vcnt = '0;
    end

    // Register writes: configuration and storage restore
    if (wr_now && ci < 6'(imsq_pkg::CFG_N)) n.cfg[ci] = hwdata; // [R24]
    if (wr_now && ni < 6'(imsq_pkg::NV_N)) n.nv[ni] = hwdata; // [R21] [R17]
    n.merr = (n.nv[imsq_pkg::NV_WASTE] >
              r.cfg[imsq_pkg::CFG_WASTELIM]); // [R18]

    // AHB-Lite address phase capture and read data
    n.wr_pend = 1'b0;
    n.rd_pend = 1'b0;
    if (r.rd_pend) begin
      n.rdata = '0;
      if (r.idx == 6'(imsq_pkg::ADDR_CMD >> 2))
        n.rdata = {28'h000_0000, r.op};
      else if (r.idx == 6'(imsq_pkg::ADDR_STAT >> 2))
        n.rdata = {22'h00_0000, r.merr, r.refused, 4'h0, r.st};
      else if (ci < 6'(imsq_pkg::CFG_N))
        n.rdata = r.cfg[ci];
      else if (ni < 6'(imsq_pkg::NV_N))
        n.rdata = r.nv[ni]; // [R21]
    end else if (hsel && htrans[1] && hready) begin
      n.wr_pend = hwrite;
      n.rd_pend = !hwrite;
      n.idx = haddr[7:2];
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.st <= imsq_pkg::ST_IDLE;
      r.nv[imsq_pkg::NV_ORD] <= imsq_pkg::ORD_RST;
    end else begin
      r <= n;
    end
  end

  // Outputs
  assign hreadyout = !r.rd_pend;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign carriage_go = r.go;
  assign carriage_dir_right = r.dir;
  assign carriage_target = r.tgt;
  assign pump_step = r.pstep;
  assign pump_on = r.pon;
  assign valve_open = r.valve;
  assign fire_black = r.fire_b;
  assign fire_color = r.fire_c;
  assign drive_power = r.dpow;
  assign drive_volt = r.volt;
  assign micro_vib = r.vib;
  assign busy = (r.st != imsq_pkg::ST_IDLE);
  assign maint_error = r.merr;
endmodule // imsq_top
`default_nettype wire

//--- imsq_pkg.sv
// Constants, offsets and state codes of the ink maintenance sequencer
package imsq_pkg;

  // ==========================================================
  // Clock and time base
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned CLK_HZ = CLK_MHZ * 1_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned BLK_RATE = 48;
  localparam int unsigned COL_RATE = 36;
  localparam int unsigned BLK_PER_CYC = CLK_HZ / BLK_RATE;
  localparam int unsigned COL_PER_CYC = CLK_HZ / COL_RATE;
  localparam int unsigned PUMP_GAP_NS = 100_000;
  localparam int unsigned PUMP_GAP_CYC = PUMP_GAP_NS * CLK_MHZ / 1000;
  localparam int unsigned SHOT_GAP_NS = 1000;
  localparam int unsigned SHOT_GAP_CYC = SHOT_GAP_NS * CLK_MHZ / 1000;
  localparam int unsigned VIB_GAP_NS = 2000;
  localparam int unsigned VIB_GAP_CYC = VIB_GAP_NS * CLK_MHZ / 1000;

  // ==========================================================
  // Shot counts and drive levels (0.1 V units)
  localparam logic [31:0] SHOTS_POWER = 32'd4000;
  localparam logic [31:0] SHOTS_NF_BLK = 32'd48;
  localparam logic [31:0] SHOTS_NF_COL = 32'd36;
  localparam logic [31:0] SHOTS_CF_BLK = 32'd200;
  localparam logic [31:0] SHOTS_CF_COL = 32'd2000;
  localparam logic [9:0] VOLT_BOOST = 10'd20;
  localparam logic [9:0] VOLT_MAX = 10'd360;
  localparam logic [31:0] PWRFAIL_INK = 32'h0000_0100;

  // ==========================================================
  // Register byte offsets and word indices
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_EVT = 8'h08;
  localparam logic [7:0] ADDR_CFG = 8'h20;
  localparam logic [7:0] ADDR_NV = 8'h40;
  localparam int unsigned CFG_N = 7;
  localparam int unsigned NV_N = 13;
  localparam int unsigned CFG_ABS = 0, CFG_FALSE = 1, CFG_MICRO = 2;
  localparam int unsigned CFG_CAPLIM = 3, CFG_WASTELIM = 4;
  localparam int unsigned CFG_VOLT = 5, CFG_CTRL = 6;
  localparam int unsigned NV_PFL = 0, NV_CLT = 1, NV_PRT = 2;
  localparam int unsigned NV_IDL = 3, NV_OFF = 4, NV_CAPB = 5;
  localparam int unsigned NV_CAPC = 6, NV_WASTE = 7, NV_USEK = 8;
  localparam int unsigned NV_USEY = 9, NV_USEM = 10, NV_USEC = 11;
  localparam int unsigned NV_ORD = 12;
  localparam logic [31:0] ORD_RST = 32'h0000_0001;

  // ==========================================================
  // Operation codes, carriage targets, states
  localparam logic [3:0] OP_NONE = 4'h0, OP_WIPE = 4'h1;
  localparam logic [3:0] OP_RUB = 4'h2, OP_ABSORB = 4'h3;
  localparam logic [3:0] OP_FALSE = 4'h4, OP_MICRO = 4'h5;
  localparam logic [3:0] OP_FLPOW = 4'h6, OP_FLNORM = 4'h7;
  localparam logic [3:0] OP_FLCLN = 4'h8, OP_CLNDONE = 4'h9;
  localparam logic [3:0] OP_NVRST = 4'ha;
  localparam logic [1:0] TGT_WIPE = 2'h0, TGT_RUB = 2'h1;
  localparam logic [1:0] TGT_FLUSH = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_MOVE = 4'b0010,
    ST_PUMP = 4'b0100,
    ST_FIRE = 4'b1000
  } imsq_st_e;

endpackage

//--- imsq_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module imsq_sync #(
  parameter int unsigned W = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lv;
  } imsq_sync_s;
  imsq_sync_s r, n;

  // ==========================================================
  // Accept a change once stages two and three agree
  always_comb begin
    n = r;
    n.s1 = pin;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) n.lv[i] = r.s3[i];
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) r <= '0;
    else r <= n;
  end

  assign level = r.lv;
endmodule // imsq_sync
`default_nettype wire

//--- imsq_top_assertions.sv
// Concurrent checks on the maintenance sequencer ports
`timescale 1ns/1ps
`default_nettype none
module imsq_top_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic cr_accel_pin,
  input wire logic carriage_go,
  input wire logic carriage_dir_right,
  input wire logic [1:0] carriage_target,
  input wire logic pump_step,
  input wire logic pump_on,
  input wire logic fire_black,
  input wire logic fire_color,
  input wire logic drive_power,
  input wire logic [9:0] drive_volt,
  input wire logic micro_vib,
  input wire logic busy
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // Actuator and bus relations
  wipe_dir_a: assert property (
    carriage_go && carriage_target == imsq_pkg::TGT_WIPE |-> carriage_dir_right)
    else $error("wipe sweep not left to right");
  rub_dir_a: assert property (
    carriage_go && carriage_target == imsq_pkg::TGT_RUB |-> !carriage_dir_right)
    else $error("rub sweep not right to left");
  pump_gated_a: assert property (pump_step |-> pump_on && busy)
    else $error("pump step outside pumping");
  fire_busy_a: assert property (
    fire_black || fire_color |-> busy && !carriage_go)
    else $error("shot outside flush");
  volt_cap_a: assert property (
    drive_power |-> drive_volt <= imsq_pkg::VOLT_MAX)
    else $error("drive level above maximum");
  shot_gap_a: assert property (fire_black |=> !fire_black [*8])
    else $error("black shots too close");
  vib_accel_a: assert property (micro_vib |-> $past(cr_accel_pin, 3) ||
    $past(cr_accel_pin, 4) || $past(cr_accel_pin, 5))
    else $error("vibration without acceleration");
  read_wait_a: assert property (
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  resp_okay_a: assert property (!hresp)
    else $error("bus response not okay");
  // Main scenarios reached
  cover property (pump_step && pump_on);
  cover property (fire_color);
  cover property (micro_vib);
endmodule // imsq_top_chk
`default_nettype wire

//--- imsq_mech_model.sv
// Carriage mechanism model answering move requests
`timescale 1ns/1ps
`default_nettype none
module imsq_mech_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic carriage_go,
  input wire logic slow,
  output logic carriage_done
);
  logic [7:0] cnt_reg;
  // ==========================================================
  // Move time counts down, done pulses once at the end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 8'h00;
      carriage_done <= 1'b0;
    end else begin
      carriage_done <= (cnt_reg == 8'h01);
      if (carriage_go) begin
        cnt_reg <= slow ? 8'h3c : 8'h03; // Slow or prompt carriage
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule // imsq_mech_model
`default_nettype wire

//--- tb_ink_maintenance_sequencer.sv
// Self-checking bench of the ink maintenance sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_ink_maintenance_sequencer;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cap, accel, pfail;
  logic slow, carriage_done, carriage_go, dir, pump_step, pump_on, valve;
  logic fire_black, fire_color, drive_power, micro_vib, busy, maint_error;
  logic v_seen, d_seen;
  logic [1:0] htrans, tgt, t_seen;
  logic [9:0] drive_volt;
  logic [31:0] haddr, hwdata, hrdata, rd, d, seed;
  int err_total, comparisons, n_go, n_step, n_fb, n_fc, n_vib, cyc, op, i, st;
  int tot;
  imsq_top #(.TICK_CYC(10), .BLK_PER(20), .COL_PER(30)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .cap_closed_pin(cap), .cr_accel_pin(accel),
    .power_fail_pin(pfail), .carriage_done(carriage_done),
    .carriage_go(carriage_go), .carriage_dir_right(dir),
    .carriage_target(tgt), .pump_step(pump_step), .pump_on(pump_on),
    .valve_open(valve), .fire_black(fire_black), .fire_color(fire_color),
    .drive_power(drive_power), .drive_volt(drive_volt),
    .micro_vib(micro_vib), .busy(busy), .maint_error(maint_error));
  imsq_mech_model u_mech (.hclk(hclk), .hresetn(hresetn),
    .carriage_go(carriage_go), .slow(slow), .carriage_done(carriage_done));
  // ==========================================================
  // Clock, event counting and hang guard
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (carriage_go) begin
      n_go <= n_go + 1;
      d_seen <= dir;
      t_seen <= tgt;
    end
    if (pump_step) n_step <= n_step + 1;
    pfail <= pump_on && op == 5; // Power lost mid-pump
    if (pump_on) v_seen <= valve;
    if (fire_black) n_fb <= n_fb + 1;
    if (fire_color) n_fc <= n_fc + 1;
    if (micro_vib) n_vib <= n_vib + 1;
    if (cyc == 60000) begin
      err_total++;
      print_verdict();
    end
  end
  // ==========================================================
  // Bus tasks and comparison
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= v;
    do @(posedge hclk); while (!hreadyout);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic run(input int c);
    n_go = 0;
    n_step = 0;
    n_fb = 0;
    n_fc = 0;
    xfer(1'b1, 8'h00, c);
    repeat (3) @(posedge hclk);
    while (busy === 1'b1) @(posedge hclk);
  endtask
  function automatic int next_order(input int k);
    return (k == 3) ? 1 : k + 1;
  endfunction
  task automatic print_verdict();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {hsel, hwrite, cap, accel, pfail, slow} = 6'h00;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    seed = 32'hd1c0_66ea;
    {err_total, comparisons, cyc, n_vib, tot} = 160'h0;
    hresetn = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, 8'h70, 0);
    chk(32'h0000_0001, rd);
    xfer(1'b0, 8'h80, 0);
    chk(32'h0000_0000, rd);
    for (i = 0; i < 5; i++) begin
      d = $random(seed);
      xfer(1'b1, 8'h20 + 4 * i, d);
      xfer(1'b0, 8'h20 + 4 * i, 0);
      chk(d, rd);
    end
    for (op = 1; op <= 2; op++) begin
      slow <= (op == 2);
      run(op);
      chk(1, n_go);
      chk(op == 1, d_seen);
    end
    cap <= 1'b1;
    xfer(1'b1, 8'h30, 32'h0000_0010);
    xfer(1'b1, 8'h2c, 32'h0000_ffff);
    xfer(1'b1, 8'h5c, 32'hffff_fffe);
    for (op = 3; op <= 5; op++) begin
      st = 1 + $unsigned($random(seed)) % 2;
      tot = tot + st;
      xfer(1'b1, 8'h20 + 4 * (op - 3), st);
      run(op);
      chk(st, n_step);
      chk(op != 3, v_seen);
    end
    xfer(1'b0, 8'h5c, 0);
    chk(32'hffff_ffff, rd);
    chk(1, maint_error);
    run(10);
    xfer(1'b0, 8'h5c, 0);
    chk(0, rd);
    chk(0, maint_error);
    xfer(1'b1, 8'h38, 32'h0000_0002);
    xfer(1'b1, 8'h08, 32'h0000_0010);
    xfer(1'b0, 8'h60, 0);
    chk(0, rd);
    cap <= 1'b0;
    repeat (8) @(posedge hclk);
    run(3);
    xfer(1'b0, 8'h04, 0);
    chk(1, rd[8]);
    chk(0, n_step);
    cap <= 1'b1;
    run(7);
    chk(48, n_fb);
    chk(36, n_fc);
    chk(imsq_pkg::TGT_FLUSH, t_seen);
    xfer(1'b0, 8'h54, 0);
    chk(48, rd);
    xfer(1'b0, 8'h68, 0);
    chk(tot + 36 + imsq_pkg::PWRFAIL_INK, rd);
    xfer(1'b1, 8'h2c, 32'h0000_0010);
    run(0);
    chk(1, n_step > 0);
    xfer(1'b0, 8'h54, 0);
    chk(0, rd);
    for (i = 0; i < 3; i++) begin
      run(9);
      xfer(1'b0, 8'h70, 0);
      chk(next_order(i + 1), rd);
    end
    xfer(1'b1, 8'h38, 32'h0000_0001);
    n_vib = 0;
    accel <= 1'b1;
    repeat (200) @(posedge hclk);
    accel <= 1'b0;
    repeat (10) @(posedge hclk);
    chk(1, n_vib >= 2);
    n_vib = 0;
    repeat (200) @(posedge hclk);
    chk(0, n_vib);
    xfer(1'b1, 8'h34, 32'h0000_015e);
    xfer(1'b1, 8'h00, 32'h0000_0006);
    while (drive_power !== 1'b1) @(posedge hclk);
    chk(imsq_pkg::VOLT_MAX, drive_volt);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, 8'h70, 0);
    chk(32'h0000_0001, rd);
    chk(0, busy);
    print_verdict();
  end
endmodule // tb_ink_maintenance_sequencer
bind imsq_top imsq_top_chk u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .cr_accel_pin(cr_accel_pin),
  .carriage_go(carriage_go), .carriage_dir_right(carriage_dir_right),
  .carriage_target(carriage_target), .pump_step(pump_step),
  .pump_on(pump_on), .fire_black(fire_black), .fire_color(fire_color),
  .drive_power(drive_power), .drive_volt(drive_volt),
  .micro_vib(micro_vib), .busy(busy));
`default_nettype wire
